// *** rtl/rpx_pkg.sv ***
// Package for the 5:6:5 to 8:8:8 pixel expander.
// Assumes a single clock and synchronous reset in the streaming fabric.
package rpx_pkg;
  localparam int RPX_WORD_W     = 64;
  localparam int RPX_PIX_IN_W   = 16;
  localparam int RPX_PIX_OUT_W  = 24;
  localparam int RPX_SYMS_BEAT  = 2;
  localparam int RPX_SYM_W      = 8;
  localparam int RPX_PIX_PER_WD = RPX_WORD_W / RPX_PIX_IN_W;
  localparam int RPX_IDX_W      = $clog2(RPX_PIX_PER_WD);
  // Source field positions of a 5:6:5 pixel.
  localparam int RPX_R_LSB = 11;
  localparam int RPX_R_W   = 5;
  localparam int RPX_G_LSB = 5;
  localparam int RPX_G_W   = 6;
  localparam int RPX_B_LSB = 0;
  localparam int RPX_B_W   = 5;
  // Destination byte positions, red in the top byte.
  localparam int RPX_OR_LSB = 16;
  localparam int RPX_OG_LSB = 8;
  localparam int RPX_OB_LSB = 0;
  localparam logic [1:0] RPX_IDX_LAST = 2'h3;
  localparam logic [1:0] RPX_IDX_FIRST = 2'h0;
endpackage : rpx_pkg

// *** rtl/rpx_word_split.sv ***
// Splits 64-bit frame-buffer words into 16-bit pixel beats.
// Assumes a valid/ready stream on both sides on the same clock.
`timescale 1ns/100ps
module rpx_word_split
  import rpx_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [RPX_WORD_W-1:0]   word_data,
  input  wire logic                    word_valid,
  input  wire logic                    word_first,
  output logic                         word_ready,
  output logic [RPX_PIX_IN_W-1:0]      pix_data,
  output logic                         pix_valid,
  output logic                         pix_first,
  input  wire logic                    pix_ready
);
  typedef struct packed {
    logic [RPX_WORD_W-1:0] word;
    logic                  full;
    logic                  first;
    logic [1:0]            idx;
  } rpx_split_t;

  rpx_split_t st;
  rpx_split_t next_st;

  // A new word is taken when none is held, or as the last pixel of the held one leaves.
  assign word_ready = !st.full || (pix_ready && st.idx == RPX_IDX_LAST);
  assign pix_valid  = st.full;
  assign pix_data   = st.word[RPX_PIX_IN_W-1:0]; // R9
  assign pix_first  = st.first && st.idx == RPX_IDX_FIRST; // R9

  always_comb begin
    next_st = st;
    if (st.full && pix_ready) begin
      next_st.word  = st.word >> RPX_PIX_IN_W; // R5
      next_st.idx   = st.idx + 2'h1;
      next_st.first = 1'b0;
      if (st.idx == RPX_IDX_LAST) begin
        next_st.full = 1'b0;
      end
    end
    if (word_valid && word_ready) begin
      next_st.word  = word_data;
      next_st.full  = 1'b1;
      next_st.first = word_first; // R9
      next_st.idx   = RPX_IDX_FIRST;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : rpx_word_split

// *** rtl/rpx_expander.sv ***
// Top of the pixel path: word splitter, 5:6:5 to 8:8:8 widening.
// Assumes the frame buffer holds aligned 5:6:5 pixels in raster order.
//
// Summary of operation
// R1 - One 16-bit pixel in, one 24-bit out.
// R2 - Pad red 3, green 2, blue 3 bits.
// R3 - Padding is zeros or LSB copy, fixed.
// R4 - Same stream ports and handshake as before.
// R5 - Adapter gives two bytes per beat, not four.
// R6 - Software stores aligned 16-bit 5:6:5 pixels.
// R7 - Output order red, green, blue bytes.
// R8 - First-pixel marker per frame, raster order.
// R9 - Lowest pixel first; marker on first only.
`timescale 1ns/100ps
module rpx_expander
  import rpx_pkg::*;
#(
  parameter bit LSB_PAD = 1'b0
)
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [RPX_WORD_W-1:0]  word_data,
  input  wire logic                   word_valid,
  input  wire logic                   frame_first_marker_in,
  output logic                        word_ready,
  output logic [RPX_PIX_OUT_W-1:0]    data_out,
  output logic                        out_valid,
  output logic                        frame_first_marker,
  input  wire logic                   out_ready
);
  typedef struct packed {
    logic [RPX_PIX_OUT_W-1:0] data;
    logic                     valid;
    logic                     first;
  } rpx_out_t;

  rpx_out_t st;
  rpx_out_t next_st;
  logic [RPX_PIX_IN_W-1:0] pix;
  logic                    pix_valid;
  logic                    pix_first;
  logic                    pix_ready;
  wire  logic [RPX_PIX_OUT_W-1:0] wide;

  // Per-channel source field and destination byte, red, green, blue.
  localparam int RPX_CHANS = 3;
  localparam int CH_SRC_LSB [RPX_CHANS] =
    '{RPX_R_LSB, RPX_G_LSB, RPX_B_LSB};
  localparam int CH_SRC_W [RPX_CHANS] =
    '{RPX_R_W, RPX_G_W, RPX_B_W};
  localparam int CH_DST_LSB [RPX_CHANS] =
    '{RPX_OR_LSB, RPX_OG_LSB, RPX_OB_LSB};

  rpx_word_split u_split (
    .clk        (clk),
    .rst        (rst),
    .word_data  (word_data),
    .word_valid (word_valid),
    .word_first (frame_first_marker_in),
    .word_ready (word_ready),
    .pix_data   (pix),
    .pix_valid  (pix_valid),
    .pix_first  (pix_first),
    .pix_ready  (pix_ready)
  );

  // A one-deep output register keeps the same valid/ready behaviour.
  assign pix_ready = !st.valid || out_ready; // R4

  // Copying the top bits lets full white reach 8'hff; zeros stop short.
  for (genvar ch = 0; ch < RPX_CHANS; ch++) begin : g_chan
    localparam int SW = CH_SRC_W[ch];
    localparam int PW = RPX_SYM_W - SW;
    wire logic [SW-1:0] src;
    assign src = pix[CH_SRC_LSB[ch] +: SW]; // R1
    if (LSB_PAD) begin : g_copy
      assign wide[CH_DST_LSB[ch] +: RPX_SYM_W] = {src, src[SW-1 -: PW]}; // R3
    end else begin : g_zero
      assign wide[CH_DST_LSB[ch] +: RPX_SYM_W] = {src, {PW{1'b0}}}; // R2
    end
  end

  always_comb begin
    next_st = st;
    // The marker is cleared with valid so that it can leave a flop directly.
    if (out_ready) begin
      next_st.valid = 1'b0;
      next_st.first = 1'b0;
    end
    if (pix_valid && pix_ready) begin
      next_st.data  = wide; // R7
      next_st.valid = 1'b1;
      next_st.first = pix_first; // R8
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign data_out           = st.data;
  assign out_valid          = st.valid;
  assign frame_first_marker = st.first; // R8
endmodule : rpx_expander

// *** verif/rpx_expander_checker.sv ***
// Port checker for the pixel expander.
// Bound to every rpx_expander instance.
`timescale 1ns/100ps
module rpx_expander_checker
  import rpx_pkg::*;
#(parameter bit LSB_PAD = 1'b0)
(
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic [RPX_WORD_W-1:0]    word_data,
  input wire logic                     word_valid,
  input wire logic                     frame_first_marker_in,
  input wire logic                     word_ready,
  input wire logic [RPX_PIX_OUT_W-1:0] data_out,
  input wire logic                     out_valid,
  input wire logic                     frame_first_marker,
  input wire logic                     out_ready
);
  logic [1:0] cnt;
  logic       pend;
  // A marked word is pending until its first pixel leaves with the marker.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt  <= 2'h0;
      pend <= 1'b0;
    end else begin
      if (out_valid && out_ready) begin
        cnt <= cnt + 2'h1;
      end
      if (word_valid && word_ready && frame_first_marker_in) begin
        pend <= 1'b1;
      end else if (frame_first_marker && out_ready) begin
        pend <= 1'b0;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_HOLD: assert property (out_valid && !out_ready |=> out_valid &&
    $stable(data_out) && $stable(frame_first_marker)) else $error("held");
  AST_MARK: assert property (frame_first_marker |-> out_valid && pend)
    else $error("marker alone");
  AST_FIRST: assert property (frame_first_marker |-> cnt == 2'h0)
    else $error("marker late");
  AST_PAD: assert property (!LSB_PAD && out_valid |->
    {data_out[18:16], data_out[9:8], data_out[2:0]} == 8'h00)
    else $error("pad");
  AST_RDY: assert property (word_valid && word_ready |=> !word_ready [*3])
    else $error("ready early");
  AST_LAT: assert property ($rose(out_valid) |->
    $past(word_valid && word_ready, 2)) else $error("latency");
  AST_GAP: assert property (out_valid && out_ready && cnt != 2'h3
    |=> out_valid) else $error("gap");
  AST_EMPTY: assert property ($fell(out_valid) |-> cnt == 2'h0)
    else $error("short word");
endmodule : rpx_expander_checker
bind rpx_expander rpx_expander_checker #(.LSB_PAD(LSB_PAD)) chk_i (.clk, .rst,
  .word_data, .word_valid, .frame_first_marker_in, .word_ready, .data_out,
  .out_valid, .frame_first_marker, .out_ready);

// *** verif/rpx_sink.sv ***
// Downstream pixel sink that may stall at random.
// Assumes the seed is set by the bench.
`timescale 1ns/100ps
module rpx_sink (
  input  wire logic clk,
  input  wire logic slow,
  output logic      out_ready
);
  always @(negedge clk) out_ready <= !slow || $urandom_range(1);
endmodule : rpx_sink

// *** verif/tb.sv ***
// Self-checking bench for the pixel expander.
// Runs a zero-padding and a bit-copying expander side by side.
// Assumes both share one randomly stalling sink.
`timescale 1ns/100ps
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wv = 1'b0;
  logic        mk = 1'b0;
  logic        slow = 1'b0;
  logic [63:0] wd = 64'h0;
  logic        word_ready, out_valid, frame_first_marker, out_ready;
  logic [23:0] data_out;
  logic        out_valid_p, frame_first_marker_p;
  logic [23:0] data_out_p;
  logic [16:0] q[$];
  logic [24:0] exp_z;
  logic [24:0] exp_l;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;
  always #50 clk = !clk;
  rpx_expander rpx_expander_i (.clk, .rst, .word_data(wd), .word_valid(wv),
    .frame_first_marker_in(mk), .word_ready, .data_out, .out_valid,
    .frame_first_marker, .out_ready);
  rpx_expander #(.LSB_PAD(1'b1)) rpx_expander_pad_i (.clk, .rst,
    .word_data(wd), .word_valid(wv), .frame_first_marker_in(mk),
    .word_ready(), .data_out(data_out_p), .out_valid(out_valid_p),
    .frame_first_marker(frame_first_marker_p), .out_ready);
  rpx_sink rpx_sink_i (.clk, .slow, .out_ready);
  function automatic logic [23:0] grow(logic [15:0] p);
    return {p[15:11], 3'h0, p[10:5], 2'h0, p[4:0], 3'h0};
  endfunction : grow
  function automatic logic [23:0] grow_lsb(logic [15:0] p);
    return {p[15:11], p[15:13], p[10:5], p[10:9], p[4:0], p[4:2]};
  endfunction : grow_lsb
  task automatic send(logic [63:0] w, logic m);
    @(negedge clk);
    wv = 1'b1;
    wd = w;
    mk = m;
    do @(posedge clk); while (word_ready !== 1'b1);
    for (int i = 0; i < 4; i++) begin
      q.push_back({m && i == 0, w[16*i +: 16]});
    end
  endtask : send
  task automatic drain(string name);
    @(negedge clk);
    wv = 1'b0;
    for (int i = 0; i < 400 && q.size() > 0; i++) @(posedge clk);
    if (q.size() != 0) begin
      miscompares++;
      $display("BAD queue exp 0 got %0d", q.size());
    end
    $display("test %s done", name);
  endtask : drain
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
      exp_z = {q[0][16], grow(q[0][15:0])};
      exp_l = {q[0][16], grow_lsb(q[0][15:0])};
      check_count++;
      if ({frame_first_marker, data_out} !== exp_z) begin
        miscompares++;
        $display("BAD pixel exp %h got %h", exp_z,
          {frame_first_marker, data_out});
      end
      if (out_valid_p !== 1'b1 ||
          {frame_first_marker_p, data_out_p} !== exp_l) begin
        miscompares++;
        $display("BAD padded exp %h got %h", exp_l,
          {frame_first_marker_p, data_out_p});
      end
      void'(q.pop_front());
    end
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h7b9e));
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    send(64'hffff_ffff_ffff_ffff, 1'b1);
    send(64'hf800_07e0_001f_0000, 1'b0);
    send(64'h0123_4567_89ab_cdef, 1'b1);
    drain("corner");
    slow = 1'b1;
    for (int i = 0; i < 30; i++) begin
      send({$urandom, $urandom}, i % 10 == 0);
    end
    drain("random stall");
    results();
  end
endmodule : tb
